/* File: verilog/fgr_regs.svh */
// Constants for the refresh granularity control block
`ifndef FGR_REGS_SVH
`define FGR_REGS_SVH

// Granularity field position in mode register three
`define FGR_FIELD_LSB 6
`define FGR_FIELD_MSB 8
`define FGR_FIELD_RESET 3'h0

// Field encodings
`define FGR_CODE_FIXED1 3'h0
`define FGR_CODE_FIXED2 3'h1
`define FGR_CODE_FIXED4 3'h2
`define FGR_CODE_OTF2 3'h5
`define FGR_CODE_OTF4 3'h6

// Clock rate and refresh timing
`define FGR_CLK_MHZ 40
`define FGR_REFI_BASE_NS 7800
`define FGR_RFC1_NS 260
`define FGR_RFC2_NS 160
`define FGR_RFC4_NS 110
`define FGR_CYC_NS 25

`endif

/* File: verilog/fgr_pkg.sv */
// Types for the refresh granularity control block
package fgr_pkg;

  typedef enum logic [1:0] {
    FGR_RATE_1X = 2'h0,
    FGR_RATE_2X = 2'h1,
    FGR_RATE_4X = 2'h3
  } fgr_rate_t;

  typedef struct packed {
    logic fixed_mode;
    logic otf_mode;
    logic reserved;
    fgr_rate_t alt_rate;
  } fgr_mode_t;

  typedef struct packed {
    logic refresh;
    logic mode_reg_set;
    logic self_refresh_entry;
    logic self_refresh_exit;
    logic bank_group_bit_zero;
    logic [2:0] mode_reg_three_field;
  } fgr_cmd_t;

  typedef enum logic [1:0] {
    FGR_ST_IDLE = 2'h0,
    FGR_ST_BUSY = 2'h1,
    FGR_ST_SELF = 2'h3
  } fgr_state_t;

endpackage

/* File: verilog/fgr_decode.sv */
// Granularity field decoder
`timescale 1ns/100ps
`include "fgr_regs.svh"

module fgr_decode (
  // Field
  input wire logic [2:0] field_in,
  // Decoded mode
  output fgr_pkg::fgr_mode_t mode_out
);

  always_comb begin
    mode_out = '0;
    mode_out.alt_rate = fgr_pkg::FGR_RATE_1X;
    case (field_in)
      `FGR_CODE_FIXED1: begin
        mode_out.fixed_mode = 1'b1;
      end
      `FGR_CODE_FIXED2: begin
        mode_out.fixed_mode = 1'b1;
        mode_out.alt_rate = fgr_pkg::FGR_RATE_2X;
      end
      `FGR_CODE_FIXED4: begin
        mode_out.fixed_mode = 1'b1;
        mode_out.alt_rate = fgr_pkg::FGR_RATE_4X;
      end
      `FGR_CODE_OTF2: begin
        mode_out.otf_mode = 1'b1;
        mode_out.alt_rate = fgr_pkg::FGR_RATE_2X;
      end
      `FGR_CODE_OTF4: begin
        mode_out.otf_mode = 1'b1;
        mode_out.alt_rate = fgr_pkg::FGR_RATE_4X;
      end
      default: begin
        mode_out.reserved = 1'b1;
      end
    endcase
  end

endmodule

/* File: verilog/fgr_cycle_timer.sv */
// Refresh cycle busy timer
`timescale 1ns/100ps

module fgr_cycle_timer #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic [WIDTH-1:0] count_in,
  // Status
  output logic busy_out
);

  logic [WIDTH-1:0] remain;
  logic [WIDTH-1:0] next_remain;

  always_comb begin
    next_remain = remain;
    if (start_in) begin
      next_remain = count_in;
    end else if (remain != '0) begin
      next_remain = remain - 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  assign busy_out = (remain != '0);

endmodule

/* File: verilog/fgr_refresh_ctrl.sv */
// Fine granularity refresh control inside the memory device
//
// Operation
// (RULE1) Decode granularity field bits 8..6: fixed 1x/2x/4x, on-the-fly 1x/2x, 1x/4x.
// (RULE2) Controller enables on-the-fly mode by mode set before on-the-fly refreshes.
// (RULE3) On-the-fly modes: bank group bit zero per refresh picks 1x or alternate.
// (RULE4) 1x rate: refresh every 7.8 us, cycle time at least 260 ns.
// (RULE5) 2x rate: refresh every half base interval, cycle time 160 ns.
// (RULE6) 4x rate: refresh every quarter base interval, cycle time 110 ns.
// (RULE7) Only refresh kinds allowed by the current mode may be issued.
// (RULE8) New interval and cycle time apply from each rate change or refresh.
// (RULE9) 2x modes: even double refreshes since last rate mode set before next.
// (RULE10) On-the-fly 1x/2x: even double refreshes between two normal refreshes.
// (RULE11) 4x modes: multiple of four quad refreshes before next rate mode set.
// (RULE12) On-the-fly 1x/4x: multiple of four quad refreshes between normal refreshes.
// (RULE13) Fixed 1x unrestricted; fixed/on-the-fly swap at same rate is no change.
// (RULE14) Temperature-controlled refresh requires field kept at 000.
// (RULE15) Self-refresh entry accepted any time regardless of refresh count; code accepts entry only while the cycle timer is idle.
// (RULE16) 2x modes: odd count before self refresh needs extra refreshes after exit.
// (RULE17) 4x modes: partial group before self refresh needs extra refreshes after exit.
// (RULE18) Controller keeps modulo-four count cleared by normal, exit or rate change.
`timescale 1ns/100ps
`include "fgr_regs.svh"

module fgr_refresh_ctrl #(
  parameter int REFI_BASE_NS = `FGR_REFI_BASE_NS,
  parameter int CYC_NS = `FGR_CYC_NS
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Decoded commands from the command path
  input fgr_pkg::fgr_cmd_t cmd_in,
  // Temperature-controlled refresh enable from mode registers
  input wire logic temp_ctrl_refresh_in,
  // Register port
  input wire logic [1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Status
  output logic [2:0] refresh_granularity_field_out,
  output fgr_pkg::fgr_rate_t active_rate_out,
  output logic refresh_busy_out,
  output logic [15:0] refresh_interval_cycles_out,
  output logic refresh_normal_cmd_out,
  output logic refresh_double_cmd_out,
  output logic refresh_quad_cmd_out,
  output logic illegal_cmd_out,
  output logic [1:0] partial_count_out,
  output logic extra_refresh_needed_out,
  output logic self_refresh_out
);

  // Cycle counts, rounded up for minimum times, down for intervals
  localparam int RFC1_CYC = (`FGR_RFC1_NS + CYC_NS - 1) / CYC_NS;
  localparam int RFC2_CYC = (`FGR_RFC2_NS + CYC_NS - 1) / CYC_NS;
  localparam int RFC4_CYC = (`FGR_RFC4_NS + CYC_NS - 1) / CYC_NS;
  localparam int REFI1_CYC = REFI_BASE_NS / CYC_NS;
  localparam int REFI2_CYC = REFI_BASE_NS / (2 * CYC_NS);
  localparam int REFI4_CYC = REFI_BASE_NS / (4 * CYC_NS);
  localparam int TW = 5;

  // Register map word indices
  localparam logic [1:0] ADDR_FIELD = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_TIMING = 2'h2;

  function automatic logic [TW-1:0] rfc_of(input fgr_pkg::fgr_rate_t rate);
    case (rate)
      fgr_pkg::FGR_RATE_2X: rfc_of = TW'(RFC2_CYC);
      fgr_pkg::FGR_RATE_4X: rfc_of = TW'(RFC4_CYC);
      default: rfc_of = TW'(RFC1_CYC);
    endcase
  endfunction

  function automatic logic [15:0] refi_of(input fgr_pkg::fgr_rate_t rate);
    case (rate)
      fgr_pkg::FGR_RATE_2X: refi_of = 16'(REFI2_CYC);
      fgr_pkg::FGR_RATE_4X: refi_of = 16'(REFI4_CYC);
      default: refi_of = 16'(REFI1_CYC);
    endcase
  endfunction

  // Field state
  logic [2:0] field;
  logic [2:0] next_field;
  fgr_pkg::fgr_mode_t mode;
  fgr_pkg::fgr_mode_t new_mode;
  fgr_pkg::fgr_rate_t rate;
  fgr_pkg::fgr_rate_t next_rate;
  logic [1:0] count;
  logic [1:0] next_count;
  logic extra;
  logic next_extra;
  logic illegal;
  logic next_illegal;
  logic [2:0] ref_kind;
  logic [2:0] next_ref_kind;
  fgr_pkg::fgr_state_t state;
  fgr_pkg::fgr_state_t next_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic busy;
  logic start;
  fgr_pkg::fgr_rate_t cmd_rate;
  logic [2:0] mrs_field;
  logic sw_set;

  fgr_decode cur_dec (
    .field_in(field),
    .mode_out(mode)
  );

  fgr_decode new_dec (
    .field_in(mrs_field),
    .mode_out(new_mode)
  );

  fgr_cycle_timer #(
    .WIDTH(TW)
  ) rfc_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(start),
    .count_in(rfc_of(cmd_rate)),
    .busy_out(busy)
  );

  assign sw_set = wr_in && (addr_in == ADDR_FIELD);
  assign mrs_field = sw_set ? wdata_in[2:0] : cmd_in.mode_reg_three_field;

  // Rate of an incoming refresh
  always_comb begin
    cmd_rate = fgr_pkg::FGR_RATE_1X;
    if (mode.otf_mode) begin
      if (cmd_in.bank_group_bit_zero) begin // see (RULE3)
        cmd_rate = mode.alt_rate;
      end
    end else begin
      cmd_rate = mode.alt_rate; // see (RULE1)
    end
  end

  assign start = cmd_in.refresh && !busy && (state != fgr_pkg::FGR_ST_SELF);

  always_comb begin
    next_field = field;
    next_rate = rate;
    next_count = count;
    next_extra = extra;
    next_illegal = 1'b0;
    next_ref_kind = 3'h0;
    next_state = state;
    case (state)
      fgr_pkg::FGR_ST_IDLE, fgr_pkg::FGR_ST_BUSY: begin
        // Commands wait only for the cycle timer, not for the state register
        next_state = busy ? fgr_pkg::FGR_ST_BUSY : fgr_pkg::FGR_ST_IDLE;
        if (!busy && cmd_in.refresh) begin
          next_state = fgr_pkg::FGR_ST_BUSY;
          next_rate = cmd_rate; // see (RULE8)
          next_ref_kind = {cmd_rate == fgr_pkg::FGR_RATE_4X,
                           cmd_rate == fgr_pkg::FGR_RATE_2X,
                           cmd_rate == fgr_pkg::FGR_RATE_1X};
          // Odd refresh out of its group, or a refresh in a reserved mode
          next_illegal = mode.reserved // see (RULE7)
            || ((cmd_rate == fgr_pkg::FGR_RATE_1X) && (count != 2'h0)); // see (RULE10) (RULE12)
          if (cmd_rate == fgr_pkg::FGR_RATE_1X) begin
            next_count = 2'h0;
            next_extra = 1'b0;
          end else begin
            next_count = count + 2'h1;
            if (cmd_rate == fgr_pkg::FGR_RATE_2X) begin
              next_count[1] = 1'b0;
            end
          end
        end else if (!busy && (cmd_in.mode_reg_set || sw_set)) begin
          next_field = mrs_field; // see (RULE1)
          next_illegal = (temp_ctrl_refresh_in && (mrs_field != `FGR_CODE_FIXED1)) // see (RULE14)
            || ((new_mode.alt_rate != mode.alt_rate) && (count != 2'h0)); // see (RULE9) (RULE11)
          // Same-rate swap keeps count; a fixed mode always runs at its own rate
          if (new_mode.alt_rate != mode.alt_rate) begin // see (RULE13)
            next_count = 2'h0;
            next_rate = fgr_pkg::FGR_RATE_1X;
          end
          if (new_mode.fixed_mode) begin
            next_rate = new_mode.alt_rate; // see (RULE8)
          end
        end else if (!busy && cmd_in.self_refresh_entry) begin
          next_state = fgr_pkg::FGR_ST_SELF; // see (RULE15)
          next_extra = (count != 2'h0); // see (RULE16) (RULE17)
        end
      end
      fgr_pkg::FGR_ST_SELF: begin
        if (cmd_in.self_refresh_exit) begin
          next_state = fgr_pkg::FGR_ST_IDLE;
          next_count = 2'h0;
        end
      end
      default: begin
        next_state = fgr_pkg::FGR_ST_IDLE;
      end
    endcase
  end

  always_comb begin
    next_rdata = 32'h0;
    if (rd_in) begin
      case (addr_in)
        ADDR_FIELD: next_rdata = {29'h0, field};
        ADDR_STATUS: next_rdata = {24'h0, extra, state == fgr_pkg::FGR_ST_SELF,
                                   busy, count, rate, 1'b0};
        ADDR_TIMING: next_rdata = {16'h0, refi_of(rate)}; // see (RULE4) (RULE5) (RULE6)
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      field <= `FGR_FIELD_RESET;
      rate <= fgr_pkg::FGR_RATE_1X;
      count <= 2'h0;
      extra <= 1'b0;
      illegal <= 1'b0;
      ref_kind <= 3'h0;
      state <= fgr_pkg::FGR_ST_IDLE;
      rdata <= 32'h0;
    end else begin
      field <= next_field;
      rate <= next_rate;
      count <= next_count;
      extra <= next_extra;
      illegal <= next_illegal;
      ref_kind <= next_ref_kind;
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  assign rdata_out = rdata;
  assign refresh_granularity_field_out = field;
  assign active_rate_out = rate;
  assign refresh_busy_out = busy;
  assign refresh_interval_cycles_out = refi_of(rate);
  assign refresh_normal_cmd_out = ref_kind[0];
  assign refresh_double_cmd_out = ref_kind[1];
  assign refresh_quad_cmd_out = ref_kind[2];
  assign illegal_cmd_out = illegal;
  assign partial_count_out = count;
  assign extra_refresh_needed_out = extra;
  assign self_refresh_out = (state == fgr_pkg::FGR_ST_SELF);

endmodule

/* File: verification/fgr_ctrl_props.sv */
// Port assertions for the refresh granularity control block
`timescale 1ns/100ps
`include "fgr_regs.svh"
module fgr_ctrl_props (
  // Clock, reset and inputs
  input wire logic clock_in,
  input wire logic rst_in,
  input fgr_pkg::fgr_cmd_t cmd_in,
  input wire logic temp_ctrl_refresh_in,
  // Observed outputs
  input wire logic [2:0] refresh_granularity_field_out,
  input fgr_pkg::fgr_rate_t active_rate_out,
  input wire logic refresh_busy_out,
  input wire logic [15:0] refresh_interval_cycles_out,
  input wire logic refresh_normal_cmd_out,
  input wire logic refresh_double_cmd_out,
  input wire logic refresh_quad_cmd_out,
  input wire logic illegal_cmd_out,
  input wire logic [1:0] partial_count_out,
  input wire logic extra_refresh_needed_out,
  input wire logic self_refresh_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic any_ref;
  assign any_ref = refresh_normal_cmd_out | refresh_double_cmd_out | refresh_quad_cmd_out;
  chk_normal_busy_len: assert property (refresh_normal_cmd_out |->
    refresh_busy_out [*8] ##1 refresh_busy_out [*3] ##1 !refresh_busy_out) else $error("normal busy");
  chk_double_busy_len: assert property (refresh_double_cmd_out |->
    refresh_busy_out [*7] ##1 !refresh_busy_out) else $error("double busy length wrong");
  chk_quad_busy_len: assert property (refresh_quad_cmd_out |->
    refresh_busy_out [*5] ##1 !refresh_busy_out) else $error("quad busy length wrong");
  chk_rate_interval: assert property ($stable(active_rate_out) |->
    refresh_interval_cycles_out == (active_rate_out == fgr_pkg::FGR_RATE_1X ? 16'h0138 :
    active_rate_out == fgr_pkg::FGR_RATE_2X ? 16'h009C : 16'h004E)) else $error("interval");
  chk_pulse_rate: assert property (any_ref |-> active_rate_out == (refresh_quad_cmd_out ?
    fgr_pkg::FGR_RATE_4X : refresh_double_cmd_out ? fgr_pkg::FGR_RATE_2X : fgr_pkg::FGR_RATE_1X))
    else $error("rate does not follow refresh kind");
  chk_kind_mode: assert property ($onehot0({refresh_normal_cmd_out, refresh_double_cmd_out,
    refresh_quad_cmd_out}) && (!refresh_double_cmd_out || refresh_granularity_field_out inside
    {`FGR_CODE_FIXED2, `FGR_CODE_OTF2}) && (!refresh_quad_cmd_out ||
    refresh_granularity_field_out inside {`FGR_CODE_FIXED4, `FGR_CODE_OTF4}))
    else $error("refresh kind not allowed in mode");
  chk_busy_ignore: assert property (refresh_busy_out && cmd_in.refresh |=> !any_ref)
    else $error("refresh accepted while busy");
  chk_count_step: assert property (refresh_double_cmd_out || refresh_quad_cmd_out |->
    partial_count_out == (refresh_quad_cmd_out ? $past(partial_count_out) + 2'h1 :
    {1'b0, ~$past(partial_count_out[0])})) else $error("partial count step wrong");
  chk_normal_clear: assert property (refresh_normal_cmd_out && !illegal_cmd_out |->
    partial_count_out == 2'h0 && !extra_refresh_needed_out) else $error("normal did not clear");
  chk_self_entry: assert property (cmd_in.self_refresh_entry && !cmd_in.refresh &&
    !cmd_in.mode_reg_set && !refresh_busy_out && !self_refresh_out |=> self_refresh_out &&
    ($past(partial_count_out) == 2'h0 || extra_refresh_needed_out))
    else $error("self refresh entry mishandled");
  chk_temp_flag: assert property (temp_ctrl_refresh_in && cmd_in.mode_reg_set &&
    !cmd_in.refresh && !refresh_busy_out && !self_refresh_out &&
    cmd_in.mode_reg_three_field != 3'h0 |=> illegal_cmd_out) else $error("temp ctrl not flagged");
endmodule
bind fgr_refresh_ctrl fgr_ctrl_props u_fgr_ctrl_props (.*);

/* File: verification/fgr_mc_model.sv */
// Memory controller model issuing refresh, mode set and self refresh commands
`timescale 1ns/100ps
module fgr_mc_model (
  // Clock
  input wire logic clock_in,
  // Device status
  input wire logic busy_in,
  // Commands to the device
  output fgr_pkg::fgr_cmd_t cmd_out
);
  initial cmd_out = '0;
  // Waits out the refresh cycle time unless told to push through
  task automatic send(input fgr_pkg::fgr_cmd_t c, input logic force_now);
    do @(posedge clock_in); while (busy_in && !force_now);
    cmd_out <= c;
    @(posedge clock_in);
    cmd_out <= '0;
  endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the refresh granularity control block
`timescale 1ns/100ps
`include "fgr_regs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic temp_ctrl_refresh_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] rdata_out, exp_d, lfsr = 32'h00007F5B;
  logic [2:0] refresh_granularity_field_out;
  logic [3:0] got_k, exp_k;
  fgr_pkg::fgr_rate_t active_rate_out;
  fgr_pkg::fgr_cmd_t cmd_in;
  logic refresh_busy_out, refresh_normal_cmd_out, refresh_double_cmd_out, refresh_quad_cmd_out;
  logic illegal_cmd_out, extra_refresh_needed_out, self_refresh_out;
  logic [15:0] refresh_interval_cycles_out;
  logic [1:0] partial_count_out;
  logic [31:0] rq[$];
  logic [3:0] eq[$];
  int bad_count = 0;
  int n_checks = 0;
  logic [2:0] modes [5] = '{`FGR_CODE_FIXED1, `FGR_CODE_FIXED2, `FGR_CODE_FIXED4,
    `FGR_CODE_OTF2, `FGR_CODE_OTF4};
  logic [2:0] kinds [5] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h1};
  int sh [5] = '{0, 1, 2, 1, 2};
  always #12.5 clock_in = ~clock_in;
  fgr_refresh_ctrl u_fgr_refresh_ctrl (.*);
  fgr_mc_model u_fgr_mc_model (.clock_in(clock_in), .busy_in(refresh_busy_out), .cmd_out(cmd_in));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Result watcher: read data and refresh kind pulses against the oldest note
  always @(posedge clock_in) begin
    rd_seen <= rd_in;
    #1;
    got_k = {illegal_cmd_out, refresh_normal_cmd_out, refresh_double_cmd_out,
             refresh_quad_cmd_out};
    if (rd_seen) begin
      exp_d = rq.pop_front();
      `CHK(rdata_out, exp_d)
    end
    if (got_k !== 4'h0) begin
      exp_k = (eq.size() == 0) ? 4'h0 : eq.pop_front();
      `CHK(got_k, exp_k)
    end
  end
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
  endtask
  task automatic ref_cmd(input logic bg, input logic [2:0] kind, input logic force_now);
    if (kind != 3'h0) eq.push_back({1'b0, kind});
    u_fgr_mc_model.send({4'h8, bg, 3'h0}, force_now);
  endtask
  task automatic tally_and_finish();
    // Results that never appeared count as misses
    bad_count = bad_count + eq.size() + rq.size();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 6000);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    wr(2'h3, lfsr);
    rd(2'h3, 32'h0);
    rd(2'h0, 32'h0);
    rd(2'h1, 32'h0);
    rd(2'h2, 32'h00000138);
    for (int i = 0; i < 5; i++) begin
      u_fgr_mc_model.send({5'h08, modes[i]}, 1'b0);
      if (modes[i][2]) ref_cmd(1'b0, 3'h4, 1'b0);
      for (int j = 0; j < 4; j++) begin
        lfsr = nxt(lfsr);
        ref_cmd(modes[i][2] | lfsr[0], kinds[i], 1'b0);
      end
      rd(2'h2, 32'((`FGR_REFI_BASE_NS / `FGR_CYC_NS) >> sh[i]));
      if (modes[i][2]) ref_cmd(1'b0, 3'h4, 1'b0);
    end
    ref_cmd(1'b0, 3'h4, 1'b0);
    ref_cmd(1'b0, 3'h0, 1'b1);
    repeat (12) @(posedge clock_in);
    lfsr = nxt(lfsr);
    wr(2'h0, {lfsr[31:3], `FGR_CODE_OTF2});
    rd(2'h0, 32'h00000005);
    ref_cmd(1'b1, 3'h2, 1'b0);
    u_fgr_mc_model.send(8'h20, 1'b0);
    rd(2'h1, 32'h000000CA);
    u_fgr_mc_model.send(8'h10, 1'b0);
    ref_cmd(1'b0, 3'h4, 1'b0);
    repeat (12) @(posedge clock_in);
    rd(2'h1, 32'h00000000);
    temp_ctrl_refresh_in <= 1'b1;
    eq.push_back(4'h8);
    u_fgr_mc_model.send({5'h08, `FGR_CODE_FIXED2}, 1'b0);
    temp_ctrl_refresh_in <= 1'b0;
    rd(2'h0, 32'h00000001);
    rd(2'h2, 32'h0000009C);
    u_fgr_mc_model.send({5'h08, `FGR_CODE_OTF2}, 1'b0);
    ref_cmd(1'b1, 3'h2, 1'b0);
    eq.push_back(4'hC);
    ref_cmd(1'b0, 3'h0, 1'b0);
    u_fgr_mc_model.send({5'h08, 3'h7}, 1'b0);
    eq.push_back(4'hC);
    ref_cmd(1'b0, 3'h0, 1'b0);
    u_fgr_mc_model.send({5'h08, `FGR_CODE_OTF4}, 1'b0);
    ref_cmd(1'b1, 3'h1, 1'b0);
    u_fgr_mc_model.send(8'h20, 1'b0);
    rd(2'h1, 32'h000000CE);
    u_fgr_mc_model.send(8'h10, 1'b0);
    ref_cmd(1'b0, 3'h4, 1'b0);
    ref_cmd(1'b1, 3'h1, 1'b0);
    eq.push_back(4'h8);
    u_fgr_mc_model.send({5'h08, `FGR_CODE_FIXED1}, 1'b0);
    repeat (4) @(posedge clock_in);
    tally_and_finish();
  end
endmodule
